// ---- include/hir_pkg.sv ----
/*
 * Constants and types shared by the host interrupt reporter.
 * Assumes nothing of its surroundings beyond a single synchronous clock domain.
 */
`default_nettype none

package hir_pkg;

    // system source vector and event word widths
    localparam int SYS_W       = 16;
    localparam int EVT_W       = 16;
    // three priority queues, each a small fifo
    localparam int NUM_Q       = 3;
    localparam int Q_DEPTH     = 8;
    localparam int Q_PTR_W     = 3;
    localparam int Q_CNT_W     = 4;

    // report kind codes in the indication word
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_SYS  = 2'h1;
    localparam logic [1:0] KIND_EVT  = 2'h2;

    // reset values
    localparam logic [SYS_W-1:0] SYS_RST  = 16'h0000;
    localparam logic [SYS_W-1:0] MASK_RST = 16'hFFFF;
    localparam logic             INT_RST  = 1'h1;

    typedef struct packed {
        logic [1:0]       kind;
        logic [1:0]       queue;
        logic [SYS_W-1:0] sys;
        logic [EVT_W-1:0] evt;
    } hir_report_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_REPORT = 3'h2,
        ST_CLEAR  = 3'h4
    } hir_state_t;

endpackage

`default_nettype wire

// ---- include/hir_q_if.sv ----
/*
 * Interface carrying the push and pop sides of one event queue.
 * Assumes the producer and the queue share the reporter's clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface hir_q_if;
    import hir_pkg::*;
    logic             push;
    logic [EVT_W-1:0] push_data;
    logic             push_ready;
    logic             pop;
    logic [EVT_W-1:0] head;
    logic             not_empty;

    modport queue (
        input  push,
        input  push_data,
        output push_ready,
        input  pop,
        output head,
        output not_empty
    );
    modport user (
        output push,
        output push_data,
        input  push_ready,
        output pop,
        input  head,
        input  not_empty
    );
endinterface

`default_nettype wire

// ---- hw/hir_event_fifo.sv ----
/*
 * One first-in first-out event queue built from flip-flops.
 * Assumes pushes and pops arrive on the reporter's clock; a push when full is dropped.
 */
`timescale 1ns/1ps
`default_nettype none

module hir_event_fifo
    import hir_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // queue sides
    hir_q_if.queue   q
);

    logic [EVT_W-1:0]   mem [Q_DEPTH];
    logic [Q_PTR_W-1:0] wr_ptr;
    logic [Q_PTR_W-1:0] rd_ptr;
    logic [Q_CNT_W-1:0] count;

    wire do_push = q.push && q.push_ready;
    wire do_pop  = q.pop && q.not_empty;

    assign q.push_ready = (count != Q_CNT_W'(Q_DEPTH));
    assign q.not_empty  = (count != '0);
    assign q.head       = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr] <= q.push_data;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= wr_ptr + Q_PTR_W'(do_push);
            rd_ptr <= rd_ptr + Q_PTR_W'(do_pop);
            count  <= count + Q_CNT_W'(do_push) - Q_CNT_W'(do_pop);
        end
    end

endmodule

`default_nettype wire

// ---- hw/hir_reporter.sv ----
/*
 * Host interrupt reporter: system sources and three event queues behind one
 * active-low level interrupt, cleared by the host reading the indication word.
 * Assumes event producers and the host read strobe are on the same clock;
 * raw system source lines come from the same domain as well.
 */
`timescale 1ns/1ps
`default_nettype none

module hir_reporter
    import hir_pkg::*;
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // system interrupt sources, one-cycle set pulses
    input  wire logic [SYS_W-1:0] sys_set,
    input  wire logic [SYS_W-1:0] sys_mask,
    // event producers, one per priority queue
    input  wire logic [NUM_Q-1:0] evt_push,
    input  wire logic [EVT_W-1:0] evt_data [NUM_Q],
    output logic      [NUM_Q-1:0] evt_ready,
    // deferral of the two low-priority queues
    input  wire logic             event_delay,
    // host side
    input  wire logic             ind_read,
    output logic      [1:0]       ind_kind,
    output logic      [1:0]       ind_queue,
    output logic      [SYS_W-1:0] ind_sys,
    output logic      [EVT_W-1:0] ind_evt,
    output logic                  int_n
);

    ////////////////////////////////////////////////////////////////////////////
    // queues

    hir_q_if qif [NUM_Q] ();

    logic [NUM_Q-1:0]  q_ne;
    logic [NUM_Q-1:0]  q_pop;
    logic [EVT_W-1:0]  q_head [NUM_Q];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_Q; gi++) begin : g_q
            assign qif[gi].push      = evt_push[gi];
            assign qif[gi].push_data = evt_data[gi];
            assign qif[gi].pop       = q_pop[gi];
            assign evt_ready[gi]     = qif[gi].push_ready;
            assign q_ne[gi]          = qif[gi].not_empty;
            assign q_head[gi]        = qif[gi].head;
            hir_event_fifo u_fifo (
                .clock (clock),
                .nrst  (nrst),
                .q     (qif[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // system source register

    logic [SYS_W-1:0] sys_src;
    wire  [SYS_W-1:0] sys_live = sys_src & ~sys_mask;
    wire              sys_pend = |sys_live;

    ////////////////////////////////////////////////////////////////////////////
    // report selection

    // picks the highest-priority pending source
    function automatic logic [2:0] pick(input logic sp, input logic [NUM_Q-1:0] ne);
        logic [2:0] r;
        r = 3'h0;
        if (sp) begin
            r = 3'h4;
        end else if (ne[0]) begin
            r = 3'h1;
        end else if (ne[1]) begin
            r = 3'h2;
        end else if (ne[2]) begin
            r = 3'h3;
        end
        return r;
    endfunction

    // queue head by index; an index past the last queue reads as zero rather
    // than running off the end of the array
    function automatic logic [EVT_W-1:0] head_of(input logic [EVT_W-1:0] h [NUM_Q],
                                                 input logic [1:0]       idx);
        logic [EVT_W-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_Q; i++) begin
            if (idx == 2'(i)) begin
                r = h[i];
            end
        end
        return r;
    endfunction

    wire [2:0] sel       = pick(sys_pend, q_ne);
    wire       sel_sys   = (sel == 3'h4);
    wire       sel_evt   = (sel != 3'h0) && !sel_sys;
    wire [1:0] sel_q     = sel[1:0] - 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // request and deferral

    // system sources and queue 1 always raise the pin on their own
    wire       hi_pend   = sys_pend || q_ne[0];
    // queues 2 and 3 raise it only while deferral is off
    wire       lo_pend   = q_ne[1] || q_ne[2];
    wire       any_req   = hi_pend || (lo_pend && !event_delay);
    // anything at all that is still waiting to be shown
    wire       all_req   = hi_pend || lo_pend;

    // once the pin is low, deferred entries ride along in the same service
    // run; without this they would starve while the bit is set and be
    // dropped once their queue fills
    wire       pin_low   = !int_n;
    wire       go_req    = pin_low ? all_req : any_req;

    hir_report_t cur;
    hir_state_t  state;
    hir_state_t  next_state;

    // state decode used by the data path; the pin logic cases on state directly
    wire in_idle   = (state == ST_IDLE);
    wire in_report = (state == ST_REPORT);
    wire in_clear  = (state == ST_CLEAR);

    // the held report is cleared when the host reads it
    wire clear_now = in_report && ind_read;

    generate
        for (gi = 0; gi < NUM_Q; gi++) begin : g_pop
            // exactly one event leaves its queue per read of an event report
            assign q_pop[gi] = clear_now && (cur.kind == KIND_EVT)
                               && (cur.queue == 2'(gi));
        end
    endgenerate

    // cleared system bits are only those that were reported; a new set wins
    wire [SYS_W-1:0] sys_clr  = (clear_now && cur.kind == KIND_SYS) ? cur.sys : '0;
    wire [SYS_W-1:0] next_sys = (sys_src & ~sys_clr) | sys_set;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sys_src <= SYS_RST;
        end else begin
            sys_src <= next_sys;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // report state machine

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (go_req) begin
                    next_state = ST_REPORT;
                end
            end
            ST_REPORT: begin
                if (ind_read) begin
                    next_state = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // fields of the report that would be latched this cycle
    wire [1:0]       new_kind  = sel_sys ? KIND_SYS : (sel_evt ? KIND_EVT : KIND_NONE);
    wire [1:0]       new_queue = sel_evt ? sel_q : 2'h0;
    wire [SYS_W-1:0] new_sys   = sel_sys ? sys_live : '0;
    wire [EVT_W-1:0] new_evt   = sel_evt ? head_of(q_head, sel_q) : '0;
    wire             latch_now = in_idle && go_req;

    // snapshot of the report; deferral gates only the start of a run, never
    // a report already latched
    hir_report_t next_cur;
    always_comb begin
        next_cur = cur;
        if (latch_now) begin
            next_cur.kind  = new_kind;
            next_cur.queue = new_queue;
            next_cur.sys   = new_sys;
            next_cur.evt   = new_evt;
        end else if (in_clear) begin
            next_cur.kind  = KIND_NONE;
            next_cur.queue = 2'h0;
            next_cur.sys   = '0;
            next_cur.evt   = '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cur   <= '0;
        end else begin
            state <= next_state;
            cur   <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // pin stays low across a read if more remains; the clear cycle looks at
    // what is left after the pop or bit clear has taken effect
    logic next_int_n;
    always_comb begin
        case (state)
            ST_IDLE: begin
                // a fresh run obeys deferral, a running one does not
                next_int_n = !go_req;
            end
            ST_REPORT: begin
                next_int_n = 1'b0;
            end
            ST_CLEAR: begin
                // gapless: stay low while anything, deferred or not, waits
                next_int_n = !all_req;
            end
            default: begin
                next_int_n = INT_RST;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            int_n <= INT_RST;
        end else begin
            int_n <= next_int_n;
        end
    end

    assign ind_kind  = cur.kind;
    assign ind_queue = cur.queue;
    assign ind_sys   = cur.sys;
    assign ind_evt   = cur.evt;

endmodule

`default_nettype wire

// ---- verification/hir_chk.sv ----
/* port checker for the interrupt reporter.
   assumes one clock and a host that reads only while a report is shown. */
`timescale 1ns/1ps
`default_nettype none
module hir_chk
    import hir_pkg::*;
(
    // clock and reset
    input wire logic             clock,
    input wire logic             nrst,
    // sources
    input wire logic [SYS_W-1:0] sys_set,
    input wire logic [SYS_W-1:0] sys_mask,
    input wire logic [NUM_Q-1:0] evt_push,
    input wire logic             event_delay,
    // host side
    input wire logic             ind_read,
    input wire logic [1:0]       ind_kind,
    input wire logic [1:0]       ind_queue,
    input wire logic [SYS_W-1:0] ind_sys,
    input wire logic             int_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire idle    = ind_kind == KIND_NONE;
    wire new_sys = |(sys_set & ~sys_mask);
    ////////////////////////////////////////////////
    a_held_low: assert property (!idle |-> !int_n)
        else $error("report shown with int high");
    a_fall_cause: assert property ($fell(int_n) |-> !idle)
        else $error("int fell with no report");
    a_rise_clear: assert property ($rose(int_n) |-> idle)
        else $error("int rose with report held");
    a_read_clears: assert property (ind_read && !idle |-> ##[1:2] idle)
        else $error("read did not clear report");
    a_report_stands: assert property (
        !idle && !ind_read && !$past(ind_read) |=> $stable({ind_kind, ind_queue, ind_sys}))
        else $error("report changed before read");
    a_sys_raises: assert property (int_n && idle && new_sys |-> ##[1:3] !int_n)
        else $error("system set did not raise int");
    a_sys_unmasked: assert property (
        ind_kind == KIND_SYS && $past(idle) |-> (ind_sys & $past(sys_mask)) == '0)
        else $error("masked bit in system report");
    a_evt_queue: assert property (ind_kind == KIND_EVT |-> ind_queue < 2'h3)
        else $error("bad event queue number");
    a_defer_quiet: assert property (
        event_delay && $past(event_delay) && int_n && idle && !evt_push[0]
        && !$past(evt_push[0]) && sys_set == '0 && $past(sys_set) == '0
        && $stable(sys_mask) |=> int_n) else $error("deferred queue raised int");
    c_sys: cover property (ind_kind == KIND_SYS);
    c_low_q: cover property (ind_kind == KIND_EVT && ind_queue == 2'h2);
    c_gapless: cover property (ind_read && !idle ##2 !int_n);
    c_defer_ride: cover property (event_delay && ind_kind == KIND_EVT && ind_queue != 2'h0);
endmodule
bind hir_reporter hir_chk hir_chk_i (.clock, .nrst, .sys_set, .sys_mask, .evt_push,
    .event_delay, .ind_read, .ind_kind, .ind_queue, .ind_sys, .int_n);
`default_nettype wire

// ---- verification/hir_host_model.sv ----
/* host that services the reporter and logs each report it reads.
   assumes the reporter answers on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module hir_host_model
    import hir_pkg::*;
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // pacing from the bench
    input  wire logic             host_on,
    input  wire logic [3:0]       slow,
    // reporter side
    input  wire logic             int_n,
    input  wire logic [1:0]       ind_kind,
    input  wire logic [1:0]       ind_queue,
    input  wire logic [SYS_W-1:0] ind_sys,
    input  wire logic [EVT_W-1:0] ind_evt,
    output logic                  ind_read = 1'h0
);
    logic [35:0] seen [$];
    logic [3:0]  waited;
    ////////////////////////////////////////////////
    // reads only while a report is shown, which keeps reads at least three cycles apart
    always @(negedge clock) begin
        if (!nrst) begin
            ind_read <= 1'h0;
            waited   <= 4'h0;
        end else if (ind_read) begin
            ind_read <= 1'h0;
        end else if (host_on && int_n === 1'h0 && ind_kind !== KIND_NONE) begin
            ind_read <= waited >= slow;
            waited   <= waited >= slow ? 4'h0 : waited + 4'h1;
        end
    end
    always @(posedge clock) begin
        if (ind_read === 1'h1)
            seen.push_back({ind_kind, ind_queue, ind_sys, ind_evt});
    end
endmodule
`default_nettype wire

// ---- verification/host_interrupt_reporter_tb.sv ----
/* self-checking bench for the interrupt reporter with a host model.
   assumes the checker is bound in and inputs move on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module host_interrupt_reporter_tb
    import hir_pkg::*;
;
    logic             clock, nrst, event_delay, ind_read, int_n, host_on;
    logic [3:0]       slow;
    logic [SYS_W-1:0] sys_set, sys_mask, ind_sys;
    logic [NUM_Q-1:0] evt_push, evt_ready;
    logic [EVT_W-1:0] evt_data [NUM_Q];
    logic [EVT_W-1:0] ind_evt, d;
    logic [1:0]       ind_kind, ind_queue;
    logic [35:0]      exp_q [$];
    logic [35:0]      lq [NUM_Q][$];
    int               fail_count = 0;
    int               checked = 0;
    hir_reporter hir_reporter_i (.clock, .nrst, .sys_set, .sys_mask, .evt_push, .evt_data,
        .evt_ready, .event_delay, .ind_read, .ind_kind, .ind_queue, .ind_sys, .ind_evt, .int_n);
    hir_host_model hir_host_model_i (.clock, .nrst, .host_on, .slow, .int_n, .ind_kind,
        .ind_queue, .ind_sys, .ind_evt, .ind_read);
    ////////////////////////////////////////////////
    // queue number only matters for event reports, payload by kind
    function automatic logic [35:0] key(logic [35:0] r);
        if (r[35:34] == KIND_SYS)
            return {KIND_SYS, 2'h0, r[31:16], 16'h0};
        return {r[35:32], 16'h0, r[15:0]};
    endfunction
    task automatic chk(string what, logic [35:0] seen, logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("fail_count %0d checked %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic push(int q, logic [EVT_W-1:0] v);
        @(negedge clock) evt_push[q] = 1'h1;
        evt_data[q] = v;
        @(negedge clock) evt_push[q] = 1'h0;
    endtask
    task automatic sset(logic [SYS_W-1:0] v);
        @(negedge clock) sys_set = v;
        @(negedge clock) sys_set = '0;
    endtask
    task automatic drain;
        int n;
        slow = 4'($urandom_range(0, 6));
        for (n = 0; n < 3000 && hir_host_model_i.seen.size() < exp_q.size(); n++)
            @(negedge clock);
        repeat (6) @(negedge clock);
        chk("count", 36'(hir_host_model_i.seen.size()), 36'(exp_q.size()));
        while (exp_q.size() > 0 && hir_host_model_i.seen.size() > 0)
            chk("report", key(hir_host_model_i.seen.pop_front()), exp_q.pop_front());
        chk("int_n idle", 36'(int_n), 36'h1);
        exp_q = {};
    endtask
    ////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    initial begin
        #1000000;
        fail_count++;
        stop_test();
    end
    initial begin
        {nrst, sys_set, evt_push, event_delay, host_on, slow} = '0;
        sys_mask = 16'hFF00;
        evt_data = '{default: 16'h0};
        void'($urandom(32'h33FAB698));
        repeat (10) @(posedge clock);
        @(negedge clock) nrst = 1'h1;
        chk("ready", 36'(evt_ready), 36'h7);
        chk("int_n reset", 36'(int_n), 36'h1);
        // host held off: one system report latches, queues pile up behind it
        d = 16'($urandom_range(1, 255));
        sset(d | 16'h0300);
        exp_q.push_back({KIND_SYS, 2'h0, d, 16'h0});
        for (int q = NUM_Q - 1; q >= 0; q--) begin
            for (int i = 0; i < (q == 0 ? Q_DEPTH + 1 : 2); i++) begin
                d = 16'($urandom());
                if (i < Q_DEPTH)
                    lq[q].push_back({KIND_EVT, 2'(q), 16'h0, d});
                push(q, d);
            end
        end
        chk("full", 36'(evt_ready), 36'h6);
        for (int q = 0; q < NUM_Q; q++)
            exp_q = {exp_q, lq[q]};
        host_on = 1'h1;
        drain();
        // masked bits were kept and show once unmasked
        @(negedge clock) sys_mask = 16'h0000;
        exp_q.push_back({KIND_SYS, 2'h0, 16'h0300, 16'h0});
        drain();
        // low queues wait behind the deferral bit
        event_delay = 1'h1;
        for (int q = 1; q < NUM_Q; q++) begin
            d = 16'($urandom());
            lq[q] = {{KIND_EVT, 2'(q), 16'h0, d}};
            push(q, d);
        end
        repeat (8) @(negedge clock);
        chk("deferred", 36'(int_n), 36'h1);
        // a system report opens the run and the deferred events follow it
        sset(16'h8001);
        exp_q.push_back({KIND_SYS, 2'h0, 16'h8001, 16'h0});
        exp_q = {exp_q, lq[1], lq[2]};
        drain();
        // with deferral off the low queues raise the pin by themselves
        event_delay = 1'h0;
        for (int q = 1; q < NUM_Q; q++) begin
            d = 16'($urandom());
            exp_q.push_back({KIND_EVT, 2'(q), 16'h0, d});
            push(q, d);
        end
        drain();
        // reset in mid-run drops a pending event
        push(0, 16'hA5C3);
        nrst = 1'h0;
        repeat (3) @(negedge clock);
        chk("int_n rst", 36'(int_n), 36'h1);
        nrst = 1'h1;
        hir_host_model_i.seen = {};
        drain();
        stop_test();
    end
endmodule
`default_nettype wire
